// File: verilog/rsc_pkg.sv
/*
 * Constants, field layout and carrier types for the regulator
 * sleep and control register bank.
 * Assumes a 32-bit APB master and word indices scaled by four.
 */
package rsc_pkg;

	localparam int ADDR_W = 18;

	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_A_ON    = 16'h4075;
	localparam logic [15:0] IDX_A_SLP   = 16'h4076;
	localparam logic [15:0] IDX_B_CTL   = 16'h4077;
	localparam logic [15:0] IDX_B_ON    = 16'h4078;
	localparam logic [15:0] IDX_B_SLP   = 16'h4079;
	localparam logic [15:0] IDX_IRQ_ST  = 16'h407c;
	localparam logic [15:0] IDX_IRQ_MSK = 16'h407d;
	localparam logic [15:0] IDX_STATE   = 16'h407e;

	// Field positions
	localparam int SLOT_HI  = 15;
	localparam int SLOT_LO  = 13;
	localparam int MODE_BIT = 8;
	localparam int VSEL_HI  = 4;
	localparam int ACT_HI   = 15;
	localparam int ACT_LO   = 14;
	localparam int SRC_HI   = 12;
	localparam int SRC_LO   = 11;
	localparam int PICK_BIT = 10;
	localparam int HWM_HI   = 9;
	localparam int HWM_LO   = 8;
	localparam int FLT_BIT  = 7;
	localparam int LPL_BIT  = 0;

	// Reset values and writable bits
	localparam logic [15:0] RST_ON    = 16'h0000;
	localparam logic [15:0] RST_SLP   = 16'h0100;
	localparam logic [15:0] RST_B_CTL = 16'h0200;
	localparam logic [15:0] MSK_SLOT  = 16'he11f;
	localparam logic [15:0] MSK_B_CTL = 16'hdf81;

	// Undervoltage actions and hardware control codes
	localparam logic [1:0] ACT_OFF   = 2'h1;
	localparam logic [1:0] ACT_RESET = 2'h2;
	localparam logic [1:0] SRC_HW1   = 2'h1;
	localparam logic [1:0] SRC_HW2   = 2'h2;
	localparam logic [1:0] SRC_ANY   = 2'h3;
	localparam logic [1:0] HWM_OFF   = 2'h1;
	localparam logic [1:0] HWM_ON    = 2'h3;

	// Interrupt status bits
	localparam int IRQ_W    = 2;
	localparam int IRQ_UV_B = 0;
	localparam int IRQ_A_DN = 1;

	typedef enum logic [1:0] {
		A_OFF,
		A_ON,
		A_SLEEP
	} rsc_a_state_e;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} rsc_apb_req_s;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} rsc_apb_rsp_s;

	// One step of the power-up or sleep sequencer
	typedef struct packed {
		logic       valid;
		logic       sleep;
		logic [2:0] slot;
	} rsc_seq_s;

	typedef struct packed {
		logic       enable;
		logic       discharge;
		logic       lowPower;
		logic       lpLevel;
		logic [4:0] voltage;
	} rsc_reg_out_s;

endpackage

// File: verilog/rsc_regs.sv
/*
 * Regulator sleep and control register bank: APB slave, regulator A
 * sleep sequencing state, regulator B hardware control and undervoltage
 * handling, sticky interrupt status with mask.
 * Assumes sequencer steps, hardware inputs and undervoltage events
 * are synchronous to mclk; undervoltage arrives as a one-cycle pulse.
 */
// The implementer's own choice: the APB interface to the registers.
// Notes on behaviour
// - sleep slot 000 applies sleep voltage and mode in timeslot 5.
// - sleep slot 110 applies sleep state in slot 3, 111 in slot 1.
// - sleep slots 001 to 101 disable the regulator in slots 5 to 1.
// - under hardware enable, codes 001 to 101 pick the sleep entry slot.
// - sleep mode bit 8: 0 normal, 1 low power; resets to 1.
// - 5-bit sleep voltage code, 50mV then 100mV steps.
// - undervoltage action: ignore, regulator off, system reset, reserved.
// - every undervoltage raises an interrupt regardless of action.
// - hardware control source: none, input 1, input 2, either.
// - hardware control voltage from ON field or sleep field by bit 10.
// - hardware control mode: low power, off, low power, ON mode.
// - bit 7: disabled output discharged when 0, floating when 1.
// - bit 0 picks 50mA or 20mA low power level.
// - ON slot 110 or 111 hands enable to hardware input 1 or 2.
module rsc_regs
	import rsc_pkg::*;
(
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         srst,
	// Register bus
	input  wire rsc_apb_req_s apbReq,
	output rsc_apb_rsp_s      apbRsp,
	// Sequencer, hardware inputs and fault events
	input  wire rsc_seq_s     seq,
	input  wire logic         hwEnable1,
	input  wire logic         hwEnable2,
	input  wire logic         hwCtrl1,
	input  wire logic         hwCtrl2,
	input  wire logic         underVoltB,
	// Regulator steering
	output rsc_reg_out_s      regAOut,
	output rsc_reg_out_s      regBOut,
	output logic              systemResetReq,
	output logic              irq
);

	rsc_apb_rsp_s      apbRsp_q;
	rsc_reg_out_s      regAOut_q;
	rsc_reg_out_s      regBOut_q;
	logic              sysReset_q;
	logic              irq_q;
	logic [15:0]       aOn_q;
	logic [15:0]       aSlp_q;
	logic [15:0]       bCtl_q;
	logic [15:0]       bOn_q;
	logic [15:0]       bSlp_q;
	logic [IRQ_W-1:0]  irqSt_q;
	logic [IRQ_W-1:0]  irqSt_d;
	logic [IRQ_W-1:0]  irqMsk_q;
	logic [IRQ_W-1:0]  irqEvt;
	logic              bShut_q;
	rsc_a_state_e      aState_q;
	rsc_a_state_e      aState_d;
	logic              access;
	logic              aligned;
	logic [15:0]       curIdx;
	logic              mapped;
	logic [15:0]       rdVal;
	logic [2:0]        aOnSlot;
	logic [2:0]        aSlpSlot;
	logic              aHw;
	logic              aHwLevel;
	logic              aUpHit;
	logic              aSleepHit;
	logic              aDisCode;
	logic              aDisable;
	logic [1:0]        bSrc;
	logic [1:0]        bHwMode;
	logic              bHwSel;
	logic              bEnable;

	assign apbRsp         = apbRsp_q;
	assign regAOut        = regAOut_q;
	assign regBOut        = regBOut_q;
	assign systemResetReq = sysReset_q;
	assign irq            = irq_q;

	// Access phase taken once; pready marks the second access cycle
	// The registered answer costs a wait state but keeps decode off pready
	assign access  = apbReq.psel & apbReq.penable & ~apbRsp_q.pready;
	assign aligned = (apbReq.paddr[1:0] == 2'h0);
	assign curIdx  = apbReq.paddr[ADDR_W-1:2];

	function automatic logic wrHit(input logic [15:0] idx);
		wrHit = access && apbReq.pwrite && aligned && (curIdx == idx);
	endfunction

	// Zero-extends an interrupt register to the 16-bit read word
	function automatic logic [15:0] irqWord(input logic [IRQ_W-1:0] bits);
		irqWord = {{(16-IRQ_W){1'b0}}, bits};
	endfunction

	// True on an undervoltage while the action field holds the given code
	function automatic logic uvAction(input logic [1:0] act);
		uvAction = underVoltB && (bCtl_q[ACT_HI:ACT_LO] == act);
	endfunction

	// Timeslot in which the sleep step of a slot code happens
	// Codes 001 to 101 count down from slot 5
	function automatic logic [2:0] sleepTime(input logic [2:0] code);
		case (code)
			3'h0: sleepTime = 3'h5;
			3'h6: sleepTime = 3'h3;
			3'h7: sleepTime = 3'h1;
			default: sleepTime = 3'h6 - code;
		endcase
	endfunction

	always_comb begin
		mapped = 1'b1;
		case (curIdx)
			IDX_A_ON:    rdVal = aOn_q;
			IDX_A_SLP:   rdVal = aSlp_q;
			IDX_B_CTL:   rdVal = bCtl_q;
			IDX_B_ON:    rdVal = bOn_q;
			IDX_B_SLP:   rdVal = bSlp_q;
			IDX_IRQ_ST:  rdVal = irqWord(irqSt_q);
			IDX_IRQ_MSK: rdVal = irqWord(irqMsk_q);
			// Live state readback; writes are accepted and ignored
			IDX_STATE: begin
				rdVal = {11'h000, bShut_q, bHwSel, regBOut_q.enable,
					aState_q == A_SLEEP, regAOut_q.enable};
			end
			default: begin
				rdVal  = 16'h0000;
				mapped = 1'b0;
			end
		endcase
		if (!aligned) begin
			mapped = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			apbRsp_q <= '0;
		end else begin
			apbRsp_q.pready  <= access;
			apbRsp_q.pslverr <= access & ~mapped;
			apbRsp_q.prdata  <= (access && !apbReq.pwrite && mapped) ?
				{16'h0000, rdVal} : 32'h00000000;
		end
	end

	// Writable bits only; switch-mode and gaps stay zero
	always_ff @(posedge mclk) begin
		if (srst) begin
			aOn_q  <= RST_ON;
			aSlp_q <= RST_SLP;
			bCtl_q <= RST_B_CTL;
			bOn_q  <= RST_ON;
			bSlp_q <= RST_SLP;
		end else begin
			if (wrHit(IDX_A_ON)) begin
				aOn_q <= apbReq.pwdata[15:0] & MSK_SLOT;
			end
			if (wrHit(IDX_A_SLP)) begin
				aSlp_q <= apbReq.pwdata[15:0] & MSK_SLOT;
			end
			if (wrHit(IDX_B_CTL)) begin
				bCtl_q <= apbReq.pwdata[15:0] & MSK_B_CTL;
			end
			if (wrHit(IDX_B_ON)) begin
				bOn_q <= apbReq.pwdata[15:0] & MSK_SLOT;
			end
			if (wrHit(IDX_B_SLP)) begin
				bSlp_q <= apbReq.pwdata[15:0] & MSK_SLOT;
			end
		end
	end

	// Regulator A
	assign aOnSlot  = aOn_q[SLOT_HI:SLOT_LO];
	assign aSlpSlot = aSlp_q[SLOT_HI:SLOT_LO];
	assign aHw      = (aOnSlot[2:1] == 2'h3);
	assign aHwLevel = aOnSlot[0] ? hwEnable2 : hwEnable1;
	assign aUpHit   = seq.valid && !seq.sleep && !aHw &&
		(aOnSlot != 3'h0) && (seq.slot == aOnSlot);
	assign aSleepHit = seq.valid && seq.sleep &&
		(seq.slot == sleepTime(aSlpSlot));
	assign aDisCode = (aSlpSlot != 3'h0) && (aSlpSlot[2:1] != 2'h3);
	// A hardware-enabled regulator only sleeps, it is never cut
	assign aDisable = aSleepHit && aDisCode && !aHw;

	always_comb begin
		aState_d = aState_q;
		case (aState_q)
			A_OFF: begin
				if (aHw ? aHwLevel : aUpHit) begin
					aState_d = A_ON;
				end
			end
			A_ON: begin
				if (aHw && !aHwLevel) begin
					aState_d = A_OFF;
				end else if (aDisable) begin
					aState_d = A_OFF;
				end else if (aSleepHit) begin
					aState_d = A_SLEEP;
				end
			end
			A_SLEEP: begin
				if (aHw && !aHwLevel) begin
					aState_d = A_OFF;
				end else if (seq.valid && !seq.sleep) begin
					aState_d = A_ON;
				end
			end
			default: aState_d = A_OFF;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			aState_q <= A_OFF;
		end else begin
			aState_q <= aState_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			regAOut_q <= '0;
		end else begin
			// Next state is used so voltage and mode move with enable
			regAOut_q.enable    <= (aState_d != A_OFF);
			regAOut_q.discharge <= (aState_d == A_OFF);
			regAOut_q.lpLevel   <= 1'b0;
			if (aState_d == A_SLEEP) begin
				regAOut_q.voltage  <= aSlp_q[VSEL_HI:0];
				regAOut_q.lowPower <= aSlp_q[MODE_BIT];
			end else begin
				regAOut_q.voltage  <= aOn_q[VSEL_HI:0];
				regAOut_q.lowPower <= aOn_q[MODE_BIT];
			end
		end
	end

	// Regulator B
	// Source 00 leaves regulator B under software control alone
	assign bSrc    = bCtl_q[SRC_HI:SRC_LO];
	assign bHwMode = bCtl_q[HWM_HI:HWM_LO];
	always_comb begin
		case (bSrc)
			SRC_HW1: bHwSel = hwCtrl1;
			SRC_HW2: bHwSel = hwCtrl2;
			SRC_ANY: bHwSel = hwCtrl1 | hwCtrl2;
			default: bHwSel = 1'b0;
		endcase
	end
	// No ON slot here: B stays on unless cut or switched off by mode 01
	assign bEnable = !bShut_q && !(bHwSel && bHwMode == HWM_OFF);

	// Shutdown holds until software rewrites the control register;
	// a new undervoltage in the same cycle wins
	always_ff @(posedge mclk) begin
		if (srst) begin
			bShut_q <= 1'b0;
		end else if (uvAction(ACT_OFF)) begin
			bShut_q <= 1'b1;
		end else if (wrHit(IDX_B_CTL)) begin
			bShut_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			sysReset_q <= 1'b0;
		end else begin
			sysReset_q <= uvAction(ACT_RESET);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			regBOut_q <= '0;
		end else begin
			regBOut_q.enable    <= bEnable;
			regBOut_q.discharge <= !bEnable && !bCtl_q[FLT_BIT];
			regBOut_q.lpLevel   <= bCtl_q[LPL_BIT];
			if (bHwSel && bCtl_q[PICK_BIT]) begin
				regBOut_q.voltage <= bSlp_q[VSEL_HI:0];
			end else begin
				regBOut_q.voltage <= bOn_q[VSEL_HI:0];
			end
			if (bHwSel && bHwMode != HWM_ON) begin
				regBOut_q.lowPower <= 1'b1;
			end else begin
				regBOut_q.lowPower <= bOn_q[MODE_BIT];
			end
		end
	end

	// Interrupts: sticky status, write one to clear, set wins
	always_comb begin
		irqEvt = '0;
		irqEvt[IRQ_UV_B] = underVoltB;
		irqEvt[IRQ_A_DN] = aDisable && aState_q == A_ON;
		irqSt_d = irqSt_q;
		if (wrHit(IDX_IRQ_ST)) begin
			irqSt_d = irqSt_q & ~apbReq.pwdata[IRQ_W-1:0];
		end
		irqSt_d = irqSt_d | irqEvt;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			irqSt_q <= '0;
		end else begin
			irqSt_q <= irqSt_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			// Mask bits beyond the event count read back as zero
			irqMsk_q <= '0;
		end else if (wrHit(IDX_IRQ_MSK)) begin
			irqMsk_q <= apbReq.pwdata[IRQ_W-1:0];
		end
	end

	// Level output follows next-state so an event shows one cycle later
	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irqSt_d & irqMsk_q);
		end
	end

endmodule

// File: dv/rsc_regs_props.sv
/* Port checker for the regulator register bank.
   Bound to rsc_regs; sees only its ports, one clock domain. */
module rsc_regs_props
	import rsc_pkg::*;
(
	// Clock and reset
	input wire logic		mclk,
	input wire logic		srst,
	// Watched ports
	input wire rsc_apb_req_s	apbReq,
	input wire rsc_apb_rsp_s	apbRsp,
	input wire logic		underVoltB,
	input wire rsc_reg_out_s	regAOut,
	input wire logic		systemResetReq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (srst);

	logic	acc;
	assign acc = apbReq.psel && apbReq.penable && !apbRsp.pready;

	a_ready_next: assert property (acc |=> apbRsp.pready)
		else $error("no ready after access");
	a_ready_once: assert property (apbRsp.pready |=> !apbRsp.pready)
		else $error("ready held too long");
	a_err_unaligned: assert property (acc && apbReq.paddr[1:0] != 2'h0
		|=> apbRsp.pslverr) else $error("unaligned access not refused");
	a_err_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
		else $error("error without ready");
	a_rdata_upper: assert property (apbRsp.prdata[31:16] == 16'h0)
		else $error("upper read bits set");
	a_rdata_idle: assert property (!apbRsp.pready |-> apbRsp.prdata == 32'h0)
		else $error("read data outside answer");
	a_reset_cause: assert property
		(systemResetReq |-> $past(underVoltB))
		else $error("reset request without undervoltage");
	a_reset_pulse: assert property
		(systemResetReq |=> !systemResetReq)
		else $error("reset request held");
	a_off_discharge: assert property
		(!$past(srst) && !regAOut.enable |-> regAOut.discharge)
		else $error("disabled output not discharged");
endmodule

bind rsc_regs rsc_regs_props chk (.mclk(mclk), .srst(srst),
	.apbReq(apbReq), .apbRsp(apbRsp), .underVoltB(underVoltB),
	.regAOut(regAOut), .systemResetReq(systemResetReq));

// File: dv/tb_rsc_regs.sv
/* Directed testbench for rsc_regs over APB.
   Waits up to 20 cycles for each APB answer; assumes registered outputs. */
module tb_rsc_regs
	import rsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
	$display("wrong value t=%0t got %h exp %h", $time, a, e); end end

	logic		mclk = 1'b0;
	logic		srst = 1'b1;
	rsc_apb_req_s	apbReq = '0;
	rsc_apb_rsp_s	apbRsp;
	rsc_seq_s	seq = '0;
	logic		hwEnable1 = 1'b0;
	logic		hwEnable2 = 1'b0;
	logic		hwCtrl1 = 1'b0;
	logic		hwCtrl2 = 1'b0;
	logic		underVoltB = 1'b0;
	rsc_reg_out_s	regAOut;
	rsc_reg_out_s	regBOut;
	logic		systemResetReq;
	logic		irq;
	int		fails = 0;
	int		checks = 0;
	logic [31:0]	rdat;
	logic		err;
	logic [2:0]	code;
	logic [2:0]	ts;
	logic		dis;
	logic		sel;

	always #4 mclk = ~mclk;

	rsc_regs uut (.mclk(mclk), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp),
		.seq(seq), .hwEnable1(hwEnable1), .hwEnable2(hwEnable2),
		.hwCtrl1(hwCtrl1), .hwCtrl2(hwCtrl2), .underVoltB(underVoltB),
		.regAOut(regAOut), .regBOut(regBOut),
		.systemResetReq(systemResetReq), .irq(irq));

	function automatic logic [17:0] ba(input logic [15:0] idx);
		return {idx, 2'b00};
	endfunction

	task automatic pause(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// Reads right after an edge see the values sampled at that edge
	task automatic xfer(input logic w, input logic [17:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		apbReq <= '{1'b1, 1'b0, w, a, d};
		@(posedge mclk);
		apbReq.penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (apbRsp.pready !== 1'b1 && n < 20);
		if (n >= 20)
			fails++;
		rdat = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq <= '0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [17:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [17:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		`CHK(rdat, e)
	endtask

	task automatic step(input logic s, input logic [2:0] t);
		seq <= '{1'b1, s, t};
		@(posedge mclk);
		seq <= '0;
		pause(1);
	endtask

	task automatic complete_run;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		pause(20000);
		fails++;
		complete_run();
	end

	initial begin
		pause(3);
		srst <= 1'b0;
		rd(ba(IDX_A_SLP), 32'h100);
		rd(ba(IDX_B_CTL), 32'h200);
		rd(ba(IDX_A_ON), 32'h0);
		rd(ba(IDX_B_ON), 32'h0);
		rd(ba(IDX_B_SLP), 32'h100);
		rd(ba(IDX_IRQ_MSK), 32'h0);
		wr(ba(IDX_A_SLP), 32'hffffffff);
		rd(ba(IDX_A_SLP), 32'he11f);
		wr(ba(IDX_B_CTL), 32'hffffffff);
		rd(ba(IDX_B_CTL), 32'hdf81);
		xfer(1'b0, ba(16'h4080), 32'h0);
		`CHK(err, 1'b1)
		xfer(1'b1, ba(IDX_A_SLP) | 18'h2, 32'h0);
		`CHK(err, 1'b1)
		rd(ba(IDX_A_SLP), 32'he11f);
		$display("register map test done");
		wr(ba(IDX_A_ON), 32'h2003);
		for (int c = 0; c < 8; c++) begin
			code = c[2:0];
			ts = (code == 0) ? 3'd5 : (code == 6) ? 3'd3 :
				(code == 7) ? 3'd1 : 3'd6 - code;
			dis = code inside {[1:5]};
			wr(ba(IDX_A_SLP), {16'h0, code, 4'h0, code[0], 8'h1f});
			step(1'b0, 3'd1);
			`CHK(regAOut.voltage, 5'h03)
			step(1'b1, (ts == 3'd5) ? 3'd1 : 3'd5);
			`CHK(regAOut.enable, 1'b1)
			step(1'b1, ts);
			`CHK(regAOut.enable, !dis)
			`CHK(regAOut.discharge, dis)
			if (!dis) begin
				`CHK(regAOut.voltage, 5'h1f)
				`CHK(regAOut.lowPower, code[0])
			end
		end
		wr(ba(IDX_A_ON), 32'hc004);
		wr(ba(IDX_A_SLP), 32'h2112);
		hwEnable1 <= 1'b1;
		pause(2);
		`CHK(regAOut.enable, 1'b1)
		step(1'b1, 3'd5);
		`CHK(regAOut.enable, 1'b1)
		`CHK(regAOut.voltage, 5'h12)
		`CHK(regAOut.lpLevel, 1'b0)
		hwEnable1 <= 1'b0;
		pause(2);
		`CHK(regAOut.enable, 1'b0)
		wr(ba(IDX_A_ON), 32'he004);
		hwEnable2 <= 1'b1;
		pause(2);
		`CHK(regAOut.enable, 1'b1)
		rd(ba(IDX_STATE), 32'h5);
		$display("sleep sequence test done");
		for (int s = 0; s < 4; s++)
			for (int p = 1; p < 3; p++) begin
				wr(ba(IDX_B_CTL), {19'h0, s[1:0], 11'h100});
				hwCtrl1 <= p[0];
				hwCtrl2 <= p[1];
				pause(2);
				sel = (s[0] & p[0]) | (s[1] & p[1]);
				`CHK(regBOut.enable, !sel)
				`CHK(regBOut.discharge, sel)
			end
		wr(ba(IDX_B_ON), 32'h5);
		wr(ba(IDX_B_SLP), 32'h9);
		hwCtrl1 <= 1'b1;
		wr(ba(IDX_B_CTL), 32'h980);
		`CHK(regBOut.discharge, 1'b0)
		wr(ba(IDX_B_CTL), 32'hb00);
		`CHK(regBOut.voltage, 5'h05)
		`CHK(regBOut.lowPower, 1'b0)
		wr(ba(IDX_B_CTL), 32'hf00);
		`CHK(regBOut.voltage, 5'h09)
		wr(ba(IDX_B_CTL), 32'h801);
		`CHK(regBOut.lowPower, 1'b1)
		`CHK(regBOut.lpLevel, 1'b1)
		$display("hardware control test done");
		hwCtrl1 <= 1'b0;
		wr(ba(IDX_IRQ_MSK), 32'h1);
		for (int a = 0; a < 5; a++) begin
			if (a == 4)
				wr(ba(IDX_IRQ_MSK), 32'h0);
			wr(ba(IDX_B_CTL), {16'h0, a[1:0], 14'h200});
			wr(ba(IDX_IRQ_ST), 32'h3);
			underVoltB <= 1'b1;
			@(posedge mclk);
			underVoltB <= 1'b0;
			@(posedge mclk);
			`CHK(systemResetReq, a == 2)
			pause(1);
			`CHK(irq, a < 4)
			`CHK(regBOut.enable, a != 1)
			rd(ba(IDX_IRQ_ST), 32'h1);
			wr(ba(IDX_IRQ_ST), 32'h1);
			`CHK(irq, 1'b0)
		end
		$display("undervoltage test done");
		complete_run();
	end
endmodule
